/* File: hdl/flag_irq_timer_pins.sv */
`timescale 1ns/100ps
`include "flag_irq_timer_pins_map.svh"

module flag_irq_timer_pins
    import flag_irq_timer_pins_pkg::*;
#(
    parameter int NUM_FLAGS = 4,    // Program flag pins
    parameter int NUM_IRQS  = 4     // Interrupt request inputs
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Program flag pins
    input  wire logic [NUM_FLAGS-1:0] flagIn,
    output logic      [NUM_FLAGS-1:0] flagOut,
    output logic      [NUM_FLAGS-1:0] flagOe,
    output logic      [NUM_FLAGS-1:0] flagCondition,
    // Interrupt request pins, active low, and core side
    input  wire logic [NUM_IRQS-1:0]  irqPin_n,
    input  wire logic                 irqBootStrap,
    input  wire logic [NUM_IRQS-1:0]  irqAck,
    output logic      [NUM_IRQS-1:0]  irqToCore,
    // Timer-expired pin and timer side
    input  wire logic                 timerZeroExpired,
    input  wire logic                 timerExpiredIn,
    output logic                      timerExpiredOut,
    output logic                      timerExpiredOe,
    output logic                      timerStrap
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int SYNC_W = NUM_FLAGS + NUM_IRQS + 2;

    logic [SYNC_W-1:0]    sync1_q;          // First stage, read by stage two only
    logic [SYNC_W-1:0]    sync2_q;          // Second stage, safe to use
    logic [NUM_FLAGS-1:0] flagSync;
    logic [NUM_IRQS-1:0]  irqSync;
    logic                 timerPinSync;
    logic                 bootStrapSync;

    startup_t             state_q;          // Start-up sequencer
    startup_t             state_d;
    logic [1:0]           fillCnt_q;        // Synchroniser fill counter
    logic [1:0]           fillCnt_d;
    logic                 timerStrap_q;     // Latched timer pin strap
    logic                 timerStrap_d;
    logic                 bootStrap_q;      // Latched boot strap
    logic                 bootStrap_d;

    logic [NUM_FLAGS-1:0] flagDir_q;        // 1 drives the pin
    logic [NUM_FLAGS-1:0] flagDir_d;
    logic [NUM_FLAGS-1:0] flagOut_q;        // Driven levels
    logic [NUM_FLAGS-1:0] flagOut_d;
    logic [NUM_FLAGS-1:0] flagCond_q;       // Condition levels to sequencer
    logic [NUM_IRQS-1:0]  irqEn_q;          // Input enables
    logic [NUM_IRQS-1:0]  irqEn_d;
    logic [NUM_IRQS-1:0]  irqMode_q;        // 1 edge, 0 level
    logic [NUM_IRQS-1:0]  irqMode_d;
    logic [NUM_IRQS-1:0]  irqReq;           // Requests from detectors
    logic [NUM_IRQS-1:0]  ackAll;           // Core or software acknowledge

    pulse_count_t         pulseCnt_q;       // Remaining pulse cycles
    pulse_count_t         pulseCnt_d;

    logic                 dataPhase_q;      // Pending bus data phase
    logic                 dataPhase_d;
    logic                 writePhase_q;     // Pending phase is a write
    logic                 writePhase_d;
    logic [7:0]           addrPhase_q;      // Captured address
    logic [7:0]           addrPhase_d;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic                 addrValid;
    logic                 wrStrobe;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two stages for every asynchronous pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Idle levels: request lines high, flags and straps low,
            // so no false request edge follows reset
            sync1_q <= {2'b00, {NUM_IRQS{1'b1}}, {NUM_FLAGS{1'b0}}};
            sync2_q <= {2'b00, {NUM_IRQS{1'b1}}, {NUM_FLAGS{1'b0}}};
        end else begin
            sync1_q <= {irqBootStrap, timerExpiredIn, irqPin_n, flagIn};
            sync2_q <= sync1_q;
        end
    end

    assign flagSync      = sync2_q[NUM_FLAGS-1:0];
    assign irqSync       = sync2_q[NUM_FLAGS +: NUM_IRQS];
    assign timerPinSync  = sync2_q[NUM_FLAGS+NUM_IRQS];
    assign bootStrapSync = sync2_q[NUM_FLAGS+NUM_IRQS+1];

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequencer: wait for synchronisers, then catch straps
    always_comb begin
        state_d      = state_q;
        fillCnt_d    = fillCnt_q;
        timerStrap_d = timerStrap_q;
        bootStrap_d  = bootStrap_q;
        case (state_q)
            ST_FILL: begin
                // Pin levels need two edges to reach stage two
                fillCnt_d = fillCnt_q + 2'd1;
                if (fillCnt_d == `FITP_SYNC_FILL_CYCLES) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                timerStrap_d = timerPinSync;
                bootStrap_d  = bootStrapSync;
                state_d      = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_FILL;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= ST_FILL;
            fillCnt_q    <= 2'd0;
            timerStrap_q <= 1'b0;
            bootStrap_q  <= 1'b0;
        end else begin
            state_q      <= state_d;
            fillCnt_q    <= fillCnt_d;
            timerStrap_q <= timerStrap_d;
            bootStrap_q  <= bootStrap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    assign addrValid = hsel & hready & htrans[1];
    assign wrStrobe  = dataPhase_q & writePhase_q;

    always_comb begin
        dataPhase_d  = addrValid;
        writePhase_d = addrValid & hwrite;
        addrPhase_d  = addrValid ? haddr : addrPhase_q;
        rdata_d      = 32'h0000_0000;
        // Read data is prepared at the address phase; unmapped reads zero
        if (addrValid && !hwrite) begin
            case (haddr)
                `FITP_OFS_FLAG_DIR:  rdata_d[NUM_FLAGS-1:0] = flagDir_q;
                `FITP_OFS_FLAG_OUT:  rdata_d[NUM_FLAGS-1:0] = flagOut_q;
                `FITP_OFS_FLAG_IN:   rdata_d[NUM_FLAGS-1:0] = flagSync;
                `FITP_OFS_IRQ_EN:    rdata_d[NUM_IRQS-1:0]  = irqEn_q;
                `FITP_OFS_IRQ_MODE:  rdata_d[NUM_IRQS-1:0]  = irqMode_q;
                `FITP_OFS_IRQ_PEND:  rdata_d[NUM_IRQS-1:0]  = irqReq;
                `FITP_OFS_STRAP: begin
                    rdata_d[`FITP_STRAP_TIMER_BIT] = timerStrap_q;
                    rdata_d[`FITP_STRAP_IRQ_BIT]   = bootStrap_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dataPhase_q  <= 1'b0;
            writePhase_q <= 1'b0;
            addrPhase_q  <= 8'h00;
            rdata_q      <= 32'h0000_0000;
        end else begin
            dataPhase_q  <= dataPhase_d;
            writePhase_q <= writePhase_d;
            addrPhase_q  <= addrPhase_d;
            rdata_q      <= rdata_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Control registers: flag direction and level, request enable and mode
    always_comb begin
        flagDir_d = flagDir_q;
        flagOut_d = flagOut_q;
        irqEn_d   = irqEn_q;
        irqMode_d = irqMode_q;
        if (wrStrobe) begin
            case (addrPhase_q)
                `FITP_OFS_FLAG_DIR:  flagDir_d = hwdata[NUM_FLAGS-1:0];
                `FITP_OFS_FLAG_OUT:  flagOut_d = hwdata[NUM_FLAGS-1:0];
                `FITP_OFS_IRQ_EN:    irqEn_d   = hwdata[NUM_IRQS-1:0];
                `FITP_OFS_IRQ_MODE:  irqMode_d = hwdata[NUM_IRQS-1:0];
                default: ;
            endcase
        end
        // Strap capture overrides a colliding bus write, once only
        if (state_q == ST_SAMPLE) begin
            irqEn_d = bootStrapSync ? `FITP_RST_IRQ_EN_ON
                                    : `FITP_RST_IRQ_EN_OFF;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flagDir_q  <= `FITP_RST_FLAG_DIR;
            flagOut_q  <= `FITP_RST_FLAG_OUT;
            flagCond_q <= '0;
            irqEn_q    <= `FITP_RST_IRQ_EN_OFF;
            irqMode_q  <= `FITP_RST_IRQ_MODE;
        end else begin
            flagDir_q  <= flagDir_d;
            flagOut_q  <= flagOut_d;
            flagCond_q <= flagSync;
            irqEn_q    <= irqEn_d;
            irqMode_q  <= irqMode_d;
        end
    end

    // Output pins read back through the pad, so conditions see real levels
    assign flagOe        = flagDir_q;
    assign flagOut       = flagOut_q;
    assign flagCondition = flagCond_q;

    ////////////////////////////////////////////////////////////////////////
    // Request detectors, one per input
    // Software acknowledge: write one to the pending register
    assign ackAll = irqAck |
        ({NUM_IRQS{wrStrobe && addrPhase_q == `FITP_OFS_IRQ_PEND}}
         & hwdata[NUM_IRQS-1:0]);

    for (genvar i = 0; i < NUM_IRQS; i++) begin : g_irq
        irq_request_detect u_detect (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .pinLevel (irqSync[i]),
            .enable   (irqEn_q[i]),
            .edgeMode (irqMode_q[i]),
            .ack      (ackAll[i]),
            .request  (irqReq[i])
        );
    end

    assign irqToCore = irqReq;

    ////////////////////////////////////////////////////////////////////////
    // Timer-expired pulse; expiry during a pulse is ignored so the
    // pulse length stays exact, at the cost of losing that expiry
    always_comb begin
        pulseCnt_d = pulseCnt_q;
        if (pulseCnt_q != 3'd0) begin
            pulseCnt_d = pulseCnt_q - 3'd1;
        end else if (timerZeroExpired && state_q == ST_RUN) begin
            pulseCnt_d = `FITP_TIMER_PULSE_CYCLES;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pulseCnt_q <= 3'd0;
        end else begin
            pulseCnt_q <= pulseCnt_d;
        end
    end

    // Pin stays undriven until straps have been captured
    assign timerExpiredOe  = (state_q == ST_RUN);
    assign timerExpiredOut = (pulseCnt_q != 3'd0);
    assign timerStrap      = timerStrap_q;

endmodule : flag_irq_timer_pins

/* File: hdl/flag_irq_timer_pins_map.svh */
`ifndef FLAG_IRQ_TIMER_PINS_MAP_SVH
`define FLAG_IRQ_TIMER_PINS_MAP_SVH

// Register byte offsets on the AHB-Lite slave
`define FITP_OFS_FLAG_DIR   8'h00
`define FITP_OFS_FLAG_OUT   8'h04
`define FITP_OFS_FLAG_IN    8'h08
`define FITP_OFS_IRQ_EN     8'h0C
`define FITP_OFS_IRQ_MODE   8'h10
`define FITP_OFS_IRQ_PEND   8'h14
`define FITP_OFS_STRAP      8'h18

// Field positions in the strap register
`define FITP_STRAP_TIMER_BIT 0
`define FITP_STRAP_IRQ_BIT   1

// Reset values
`define FITP_RST_FLAG_DIR   4'h0
`define FITP_RST_FLAG_OUT   4'h0
`define FITP_RST_IRQ_EN_OFF 4'h0
`define FITP_RST_IRQ_EN_ON  4'hF
`define FITP_RST_IRQ_MODE   4'h0

// Timing counts in clk_sys cycles
`define FITP_TIMER_PULSE_CYCLES 3'd4
`define FITP_SYNC_FILL_CYCLES   2'd2

`endif

/* File: hdl/flag_irq_timer_pins_pkg.sv */
package flag_irq_timer_pins_pkg;

    // Start-up sequencer, one-hot
    typedef enum logic [2:0] {
        ST_FILL   = 3'b001,  // Synchronisers filling after reset release
        ST_SAMPLE = 3'b010,  // Straps captured this cycle
        ST_RUN    = 3'b100   // Normal operation
    } startup_t;

    // Pulse counter type for the timer-expired output
    typedef logic [2:0] pulse_count_t;

endpackage : flag_irq_timer_pins_pkg

/* File: hdl/irq_request_detect.sv */
`timescale 1ns/100ps
`include "flag_irq_timer_pins_map.svh"

module irq_request_detect
    import flag_irq_timer_pins_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic pinLevel,     // Synchronised pin, active low
    input  wire logic enable,       // Input enabled
    input  wire logic edgeMode,     // 1 edge, 0 level
    input  wire logic ack,          // Core or software acknowledge pulse
    output logic      request       // Request to core, registered
);

    logic prevLevel_q;              // Last pin level
    logic prevLevel_d;
    logic pending_q;                // Latched edge request
    logic pending_d;
    logic request_q;
    logic request_d;
    logic fallEdge;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        fallEdge    = prevLevel_q & ~pinLevel;
        prevLevel_d = pinLevel;
        pending_d   = pending_q;
        // Clear first so a same-cycle edge wins over the acknowledge
        if (ack || !edgeMode || !enable) begin
            pending_d = 1'b0;
        end
        if (edgeMode && enable && fallEdge) begin
            pending_d = 1'b1;
        end
        if (edgeMode) begin
            request_d = pending_d;
        end else begin
            request_d = enable & ~pinLevel;
        end
    end

    // Registers only; idle line is high thanks to the pull-up
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prevLevel_q <= 1'b1;
            pending_q   <= 1'b0;
            request_q   <= 1'b0;
        end else begin
            prevLevel_q <= prevLevel_d;
            pending_q   <= pending_d;
            request_q   <= request_d;
        end
    end

    assign request = request_q;

endmodule : irq_request_detect

/* File: sim/flag_irq_timer_pins_sva.sv */
`timescale 1ns/100ps
`include "flag_irq_timer_pins_map.svh"

module flag_irq_timer_pins_sva
    import flag_irq_timer_pins_pkg::*;
#(
    parameter int NUM_FLAGS = 4,    // Program flag pins
    parameter int NUM_IRQS  = 4     // Interrupt request inputs
) (
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    input wire logic                 hsel,
    input wire logic [7:0]           haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic [NUM_FLAGS-1:0] flagIn,
    input wire logic [NUM_FLAGS-1:0] flagOe,
    input wire logic [NUM_FLAGS-1:0] flagCondition,
    input wire logic [NUM_IRQS-1:0]  irqPin_n,
    input wire logic [NUM_IRQS-1:0]  irqToCore,
    input wire logic                 timerZeroExpired,
    input wire logic                 timerExpiredIn,
    input wire logic                 timerExpiredOut,
    input wire logic                 timerExpiredOe,
    input wire logic                 timerStrap
);
    ////////////////////////////////////////
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Address phase of a write to the direction register
    logic dirWrite;
    assign dirWrite = hsel && hready && htrans[1] && hwrite && haddr == `FITP_OFS_FLAG_DIR;

    dir_reset_a: assert property ($rose(reset_n) |-> flagOe == '0)
        else $error("flag drivers on after reset");
    dir_write_a: assert property ($changed(flagOe) |-> $past(dirWrite, 2))
        else $error("flag direction moved without a write");
    // Three edges through the synchroniser to the sequencer
    flag_cond_a: assert property ($past(reset_n, 3) |-> flagCondition == $past(flagIn, 3))
        else $error("flag condition not the pin three edges back");
    irq_cause_a: assert property ((irqToCore & ~$past(irqToCore) & $past(irqPin_n, 3)) == '0)
        else $error("request raised without a low pin");
    pulse_len_a: assert property (timerZeroExpired && timerExpiredOe && !timerExpiredOut
        |=> timerExpiredOut [*4] ##1 !timerExpiredOut)
        else $error("timer pulse not four cycles");
    pulse_cause_a: assert property ($rose(timerExpiredOut) |-> $past(timerZeroExpired))
        else $error("timer pulse without expiry");
    // Pin stays a strap input for three edges after release
    oe_start_a: assert property ($rose(reset_n) |-> !timerExpiredOe [*3] ##1 timerExpiredOe)
        else $error("timer pin driven at wrong time");
    strap_latch_a: assert property ($rose(timerExpiredOe) |->
        timerStrap == $past(timerExpiredIn, 3))
        else $error("strap level not latched");

    cover property (timerZeroExpired && timerExpiredOe && !timerExpiredOut);
    cover property ($changed(flagOe));
    cover property ((irqToCore & ~$past(irqToCore)) != '0);
endmodule : flag_irq_timer_pins_sva

/* File: sim/board_pins_model.sv */
`timescale 1ns/100ps

// Board side of the pins: pulls, strap resistor, external drivers
module board_pins_model (
    input  wire logic [3:0] flagOut,         // Device flag level
    input  wire logic [3:0] flagOe,          // Device drives flag
    input  wire logic [3:0] boardOe,         // Board drives flag
    input  wire logic [3:0] boardLvl,        // Board flag level
    input  wire logic [3:0] irqLow,          // Board sinks request line
    input  wire logic       strapLvl,        // Strap resistor level
    input  wire logic       timerExpiredOut, // Device timer level
    input  wire logic       timerExpiredOe,  // Device drives timer pin
    output logic      [3:0] flagIn,          // Resolved flag wires
    output logic      [3:0] irqPin_n,        // Resolved request wires
    output logic            timerExpiredIn   // Resolved timer wire
);
    // Contention shows as unknown so a double drive never hides
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (flagOe[i] && boardOe[i]) flagIn[i] = 1'bx;
            else if (flagOe[i]) flagIn[i] = flagOut[i];
            else if (boardOe[i]) flagIn[i] = boardLvl[i];
            else flagIn[i] = 1'b0; // Weak pull-down when nobody drives
        end
    end
    assign irqPin_n = ~irqLow; // Pull-up unless the board sinks
    assign timerExpiredIn = timerExpiredOe ? timerExpiredOut : strapLvl;
endmodule : board_pins_model

/* File: sim/flag_irq_timer_pins_tb.sv */
`timescale 1ns/100ps
`include "flag_irq_timer_pins_map.svh"

module flag_irq_timer_pins_tb
    import flag_irq_timer_pins_pkg::*;
;
    logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, rdyS;
    logic [7:0]  haddr;                       // Bus address
    logic [1:0]  htrans;                      // Bus transfer kind
    logic [2:0]  hsize;                       // Always a word
    logic [31:0] hwdata, hrdata, rdS, seed;   // Bus data, settled copy, random state
    logic [3:0]  flagIn, flagOut, flagOe, flagCondition, boardOe, boardLvl;
    logic [3:0]  irqPin_n, irqAck, irqToCore, irqLow;
    logic        irqBootStrap, timerZeroExpired, timerExpiredIn, timerExpiredOut;
    logic        timerExpiredOe, timerStrap, strapLvl;
    int          failures, checks_done, pulseCnt, e;

    flag_irq_timer_pins flag_irq_timer_pins_i (.clk_sys, .reset_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .flagIn,
        .flagOut, .flagOe, .flagCondition, .irqPin_n, .irqBootStrap, .irqAck, .irqToCore,
        .timerZeroExpired, .timerExpiredIn, .timerExpiredOut, .timerExpiredOe, .timerStrap);
    board_pins_model board_pins_model_i (.flagOut, .flagOe, .boardOe, .boardLvl, .irqLow,
        .strapLvl, .timerExpiredOut, .timerExpiredOe, .flagIn, .irqPin_n, .timerExpiredIn);

    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Settled values one half period before the edge that samples them
    always @(negedge clk_sys) begin
        rdS = hrdata;
        rdyS = hreadyout;
        pulseCnt += (timerExpiredOut === 1'b1);
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic end_sim();
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Bounded wait for hready; a slave that never answers ends the run
    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rdyS !== 1'b1 && n < 20);
        if (rdyS !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask : waitRdy

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy();
        q = rdS;
        chk("hresp", 32'h0, hresp);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(nm, ex, q);
    endtask : rd

    task automatic drv(input logic [3:0] v);
        @(posedge clk_sys);
        irqLow <= v;
    endtask : drv

    // Reset with both straps at one level, then check what came up
    task automatic doReset(input logic s);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        strapLvl <= s;
        irqBootStrap <= s;
        repeat (6) @(posedge clk_sys);
        chk("drivers in reset", 0, {flagOe, timerExpiredOe});
        reset_n <= 1'b1;
        repeat (5) @(negedge clk_sys);
        chk("drivers after reset", 1, {flagOe, timerExpiredOe});
        chk("timer strap", s, timerStrap);
        rd(`FITP_OFS_STRAP, {s, s}, "strap reg");
        rd(`FITP_OFS_IRQ_EN, s ? 4'hF : 4'h0, "irq enable");
    endtask : doReset

    ////////////////////////////////////////
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, boardOe, boardLvl, irqLow, irqAck} = '0;
        {irqBootStrap, timerZeroExpired, strapLvl, reset_n} = '0;
        hsize = 3'b010;
        seed = 32'hC324FA6C;
        failures = 0;
        checks_done = 0;
        doReset(1'b0);
        doReset(1'b1);
        // Random directions; the board only drives pins left as inputs
        for (int k = 0; k < 6; k++) begin
            seed = xs();
            boardOe <= 4'h0;
            wr(`FITP_OFS_FLAG_DIR, seed[3:0]);
            wr(`FITP_OFS_FLAG_OUT, seed[7:4]);
            @(posedge clk_sys);
            boardOe <= ~seed[3:0] & seed[11:8];
            boardLvl <= seed[15:12];
            e = (seed[3:0] & seed[7:4]) | (~seed[3:0] & seed[11:8] & seed[15:12]);
            repeat (5) @(negedge clk_sys);
            chk("flag oe", seed[3:0], flagOe);
            chk("flag out", seed[7:4], flagOut);
            chk("flag cond", e, flagCondition);
            rd(`FITP_OFS_FLAG_IN, e, "flag in reg");
            rd(`FITP_OFS_FLAG_DIR, seed[3:0], "flag dir reg");
        end
        // Expiry at 0, again mid-pulse (dropped), then at the minimum spacing
        pulseCnt = 0;
        for (int j = 0; j < 7; j++) begin
            @(posedge clk_sys);
            timerZeroExpired <= (j == 0 || j == 2 || j == 5);
        end
        repeat (8) @(negedge clk_sys);
        chk("pulse cycles", 8, pulseCnt);
        wr(`FITP_OFS_IRQ_MODE, 32'h5);
        rd(`FITP_OFS_IRQ_MODE, 32'h5, "irq mode reg");
        drv(4'hF);
        drv(4'h0);
        repeat (5) @(negedge clk_sys);
        chk("edge latched", 32'h5, irqToCore);
        @(posedge clk_sys);
        irqAck <= 4'h1;
        @(posedge clk_sys);
        irqAck <= 4'h0;
        repeat (2) @(negedge clk_sys);
        chk("after ack", 32'h4, irqToCore);
        wr(`FITP_OFS_IRQ_PEND, 32'h4);
        rd(`FITP_OFS_IRQ_PEND, 32'h0, "pend cleared");
        drv(4'hF);
        repeat (5) @(negedge clk_sys);
        chk("held low", 32'hF, irqToCore);
        drv(4'h0);
        repeat (5) @(negedge clk_sys);
        chk("level released", 32'h5, irqToCore);
        wr(`FITP_OFS_IRQ_EN, 32'h0);
        drv(4'hF);
        repeat (5) @(negedge clk_sys);
        chk("disabled", 32'h0, irqToCore);
        end_sim();
    end
endmodule : flag_irq_timer_pins_tb

bind flag_irq_timer_pins flag_irq_timer_pins_sva #(.NUM_FLAGS(NUM_FLAGS), .NUM_IRQS(NUM_IRQS))
    sva_i (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .flagIn, .flagOe,
    .flagCondition, .irqPin_n, .irqToCore, .timerZeroExpired, .timerExpiredIn,
    .timerExpiredOut, .timerExpiredOe, .timerStrap);
